// ==== design/arfs_pkg.sv ====
// Package: read-packet layout, reset values and counts for the ADC readback status block
package arfs_pkg;
    // Read-packet bit positions
    localparam int unsigned PKT_LEN = 438;
    localparam int unsigned POS_S2_CH = 384;
    localparam int unsigned POS_S1_CH = 392;
    localparam int unsigned POS_S2_RPT = 400;
    localparam int unsigned POS_S1_RPT = 408;
    localparam int unsigned POS_S2_FLT = 416;
    localparam int unsigned POS_S1_FLT = 418;
    localparam int unsigned POS_GLB = 420;
    localparam int unsigned POS_MIN = 424;
    localparam int unsigned POS_DONE = 437;
    // Field layouts
    localparam int unsigned VAL_W = 7;
    localparam int unsigned CH_W = 6;
    localparam int unsigned SCAN_CH_W = 5;
    localparam int unsigned NUM_CH = 32;
    localparam logic [5:0] TEMP_CH = 6'h20;
    localparam int unsigned FLT_UV = 0;
    localparam int unsigned FLT_OV = 1;
    // Reset values
    localparam logic [7:0] SLOT_RST = 8'h00;
    localparam logic [6:0] MIN_VAL_RST = 7'h7F;
    localparam logic [5:0] CH_RST = 6'h00;
    localparam logic [8:0] PKT_CNT_W0 = 9'h000;
endpackage

// ==== design/arfs_readback.sv ====
// ADC readback fault status block: measurement slots, faults, minimum search, SPI shift-out
`timescale 1ns/1ns
module arfs_readback (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic [5:0] slot_one_channel_select,
    input wire logic [5:0] slot_two_channel_select,
    input wire logic write_done,
    input wire logic [6:0] under_voltage_threshold,
    input wire logic clear_error_control,
    input wire logic min_search_refresh,
    input wire logic slot_one_conv_done,
    input wire logic [6:0] slot_one_conv_value,
    input wire logic slot_two_conv_done,
    input wire logic [6:0] slot_two_conv_value,
    input wire logic [31:0] ovt_event,
    input wire logic slot_one_skip_control,
    input wire logic slot_two_skip_control,
    input wire logic scan_step,
    input wire logic [6:0] scan_value,
    output logic [31:0] channel_uv_fault,
    output logic min_search_refresh_ack,
    output logic [7:0] meas_slot_one_report,
    output logic [7:0] meas_slot_two_report,
    output logic [12:0] lowest_drain_voltage_result,
    output logic scan_complete_flag
);
    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [1:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic sclk_prev_reg;
    logic cs_prev_reg;
    // Limitation: each link clock phase must last at least two clock
    // cycles, or an edge slips between the synchroniser samples
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclk_sync_reg <= 2'h0;
            cs_sync_reg <= 2'h3;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk};
            cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
            sclk_prev_reg <= sclk_sync_reg[1];
            cs_prev_reg <= cs_sync_reg[1];
        end
    end
    logic frame_start;
    logic frame_end;
    logic sclk_fall;
    // Frame edges come from the synchronised chip select only
    assign frame_start = cs_prev_reg & ~cs_sync_reg[1];
    assign frame_end = ~cs_prev_reg & cs_sync_reg[1];
    assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg[1] & ~cs_sync_reg[1];

    // ****************************************
    // Channel echo and slot reports
    // ****************************************
    logic [5:0] s1_ch_reg;
    logic [5:0] s2_ch_reg;
    logic [1:0] s1_flt_reg;
    logic [1:0] s2_flt_reg;
    // Echo moves only on a finished write, so a read shows the previous choice
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_ch_reg <= arfs_pkg::CH_RST;
            s2_ch_reg <= arfs_pkg::CH_RST;
        end else if (write_done) begin
            s1_ch_reg <= slot_one_channel_select;
            s2_ch_reg <= slot_two_channel_select;
        end
    end

    // Conversion wins over frame end so a fresh sample is never lost
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meas_slot_one_report <= arfs_pkg::SLOT_RST;
            meas_slot_two_report <= arfs_pkg::SLOT_RST;
        end else begin
            if (slot_one_conv_done) begin
                meas_slot_one_report <= {1'b1, slot_one_conv_value};
            end else if (frame_end) begin
                meas_slot_one_report[7] <= 1'b0;
            end
            if (slot_two_conv_done) begin
                meas_slot_two_report <= {1'b1, slot_two_conv_value};
            end else if (frame_end) begin
                meas_slot_two_report[7] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Per-channel and slot faults
    // ****************************************
    logic s1_is_vd;
    logic s2_is_vd;
    logic s1_uv;
    logic s2_uv;
    logic s1_ov;
    logic s2_ov;
    // Temperature slots never raise drain-voltage faults
    assign s1_is_vd = (s1_ch_reg < arfs_pkg::TEMP_CH);
    assign s2_is_vd = (s2_ch_reg < arfs_pkg::TEMP_CH);
    assign s1_uv = slot_one_conv_done & s1_is_vd & (slot_one_conv_value < under_voltage_threshold);
    assign s2_uv = slot_two_conv_done & s2_is_vd & (slot_two_conv_value < under_voltage_threshold);
    assign s1_ov = s1_is_vd & ovt_event[s1_ch_reg[4:0]];
    assign s2_ov = s2_is_vd & ovt_event[s2_ch_reg[4:0]];

    // Set wins over clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_flt_reg <= 2'h0;
            s2_flt_reg <= 2'h0;
        end else begin
            s1_flt_reg[arfs_pkg::FLT_UV] <= s1_uv | (s1_flt_reg[arfs_pkg::FLT_UV]
                & ~clear_error_control);
            s1_flt_reg[arfs_pkg::FLT_OV] <= s1_ov | (s1_flt_reg[arfs_pkg::FLT_OV]
                & ~clear_error_control);
            s2_flt_reg[arfs_pkg::FLT_UV] <= s2_uv | (s2_flt_reg[arfs_pkg::FLT_UV]
                & ~clear_error_control);
            s2_flt_reg[arfs_pkg::FLT_OV] <= s2_ov | (s2_flt_reg[arfs_pkg::FLT_OV]
                & ~clear_error_control);
        end
    end

    // Channel under-voltage memory, used to exclude channels from the search
    // A standing event wins over a clear in the same cycle, so its bit never drops
    logic [31:0] ch_ov_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            channel_uv_fault <= 32'h0000_0000;
            ch_ov_reg <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < arfs_pkg::NUM_CH; i++) begin
                channel_uv_fault[i] <= (channel_uv_fault[i] & ~clear_error_control)
                    | (s1_uv & (s1_ch_reg[4:0] == 5'(i)))
                    | (s2_uv & (s2_ch_reg[4:0] == 5'(i)));
                ch_ov_reg[i] <= (ch_ov_reg[i] & ~clear_error_control) | ovt_event[i];
            end
        end
    end

    // ****************************************
    // Global flags
    // ****************************************
    logic glb_uv;
    logic glb_ov;
    logic glb_skip;
    assign glb_uv = |channel_uv_fault;
    assign glb_ov = |ch_ov_reg;
    // Skip flag follows the controls live, so it clears itself
    assign glb_skip = slot_one_skip_control | slot_two_skip_control;
    logic [2:0] glb_flags;
    assign glb_flags = {glb_skip, glb_ov, glb_uv};

    // ****************************************
    // Minimum drain-voltage search
    // ****************************************
    logic [4:0] scan_ch_reg;
    logic [5:0] scan_cnt_reg;
    logic [6:0] min_val_reg;
    logic [4:0] min_ch_reg;
    logic min_valid_reg;
    logic skip_now;
    logic take_min;
    assign min_search_refresh_ack = min_search_refresh;

    // ****************************************
    // Scan skip selection
    // ****************************************
    logic s1_skip_hit;
    logic s2_skip_hit;
    logic scan_last;
    // Slot parked on temperature must not mask drain channel 0
    assign s1_skip_hit = slot_one_skip_control & s1_is_vd & (s1_ch_reg[4:0] == scan_ch_reg);
    assign s2_skip_hit = slot_two_skip_control & s2_is_vd & (s2_ch_reg[4:0] == scan_ch_reg);
    // Skipped channels still advance the scan count, only the compare is masked
    assign skip_now = s1_skip_hit | s2_skip_hit;
    assign scan_last = (scan_cnt_reg == 6'(arfs_pkg::NUM_CH - 1));
    assign take_min = scan_step & ~skip_now & ~channel_uv_fault[scan_ch_reg]
        & (scan_value < min_val_reg);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scan_ch_reg <= 5'h00;
            scan_cnt_reg <= 6'h00;
            scan_complete_flag <= 1'b0;
        end else if (min_search_refresh) begin
            scan_ch_reg <= 5'h00;
            scan_cnt_reg <= 6'h00;
            scan_complete_flag <= 1'b0;
        end else if (scan_step) begin
            scan_ch_reg <= scan_ch_reg + 5'h01;
            if (scan_last) begin
                scan_complete_flag <= 1'b1;
            end
            if (!scan_last) begin
                scan_cnt_reg <= scan_cnt_reg + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            min_val_reg <= arfs_pkg::MIN_VAL_RST;
            min_ch_reg <= 5'h00;
        end else if (min_search_refresh) begin
            // Channel field keeps the last winner until a new one is found
            min_val_reg <= arfs_pkg::MIN_VAL_RST;
        end else if (take_min) begin
            min_val_reg <= scan_value;
            min_ch_reg <= scan_ch_reg;
        end
    end

    // Valid sets at scan completion; completion wins over frame-end clear
    logic scan_finish;
    assign scan_finish = scan_step & ~min_search_refresh & ~scan_complete_flag
        & scan_last;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            min_valid_reg <= 1'b0;
        end else if (scan_finish) begin
            min_valid_reg <= 1'b1;
        end else if (min_search_refresh | frame_end) begin
            min_valid_reg <= 1'b0;
        end
    end
    assign lowest_drain_voltage_result = {min_ch_reg, min_valid_reg, min_val_reg};

    // ****************************************
    // Read-packet shift-out
    // ****************************************
    // Snapshot taken at frame start so fields stay stable for the whole shift
    logic [arfs_pkg::PKT_LEN-1:0] pkt_next;
    logic [arfs_pkg::PKT_LEN-1:0] pkt_reg;
    logic [8:0] bit_cnt_reg;
    logic shift_more;
    // Clock edges past the last packet bit are ignored
    assign shift_more = sclk_fall & (bit_cnt_reg < 9'(arfs_pkg::PKT_LEN));
    always_comb begin
        // Reserved positions read as zero
        pkt_next = '0;
        pkt_next[arfs_pkg::POS_S2_CH +: arfs_pkg::CH_W] = s2_ch_reg;
        pkt_next[arfs_pkg::POS_S1_CH +: arfs_pkg::CH_W] = s1_ch_reg;
        pkt_next[arfs_pkg::POS_S2_RPT +: 8] = meas_slot_two_report;
        pkt_next[arfs_pkg::POS_S1_RPT +: 8] = meas_slot_one_report;
        pkt_next[arfs_pkg::POS_S2_FLT +: 2] = s2_flt_reg;
        pkt_next[arfs_pkg::POS_S1_FLT +: 2] = s1_flt_reg;
        pkt_next[arfs_pkg::POS_GLB +: 3] = glb_flags;
        pkt_next[arfs_pkg::POS_MIN +: 13] = lowest_drain_voltage_result;
        pkt_next[arfs_pkg::POS_DONE] = scan_complete_flag;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pkt_reg <= '0;
            bit_cnt_reg <= arfs_pkg::PKT_CNT_W0;
            spi_miso <= 1'b0;
        end else if (frame_start) begin
            pkt_reg <= pkt_next;
            bit_cnt_reg <= 9'h001;
            spi_miso <= pkt_next[0];
        end else if (shift_more) begin
            spi_miso <= pkt_reg[bit_cnt_reg];
            bit_cnt_reg <= bit_cnt_reg + 9'h001;
        end
    end
    assign spi_miso_oe_n = cs_sync_reg[1];
endmodule

// ==== verif/arfs_readback_sva.sv ====
// Checker: port-level assertions for the readback status block
`timescale 1ns/1ns
module arfs_readback_sva (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe_n,
    input wire logic clear_error_control,
    input wire logic min_search_refresh,
    input wire logic slot_one_conv_done,
    input wire logic [6:0] slot_one_conv_value,
    input wire logic slot_two_conv_done,
    input wire logic [6:0] slot_two_conv_value,
    input wire logic scan_step,
    input wire logic [31:0] channel_uv_fault,
    input wire logic min_search_refresh_ack,
    input wire logic [7:0] meas_slot_one_report,
    input wire logic [7:0] meas_slot_two_report,
    input wire logic [12:0] lowest_drain_voltage_result,
    input wire logic scan_complete_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Steps since refresh, saturating at a full scan
    logic [5:0] step_cnt_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) step_cnt_reg <= 6'h00;
        else if (min_search_refresh) step_cnt_reg <= 6'h00;
        else if (scan_step && step_cnt_reg != 6'h20) step_cnt_reg <= step_cnt_reg + 6'h01;
    end
    a_slot_one_load: assert property (slot_one_conv_done |=>
        meas_slot_one_report == {1'b1, $past(slot_one_conv_value)}) else $error("slot one load");
    a_slot_two_load: assert property (slot_two_conv_done |=>
        meas_slot_two_report == {1'b1, $past(slot_two_conv_value)}) else $error("slot two load");
    a_refresh_ack_copy: assert property (min_search_refresh |-> min_search_refresh_ack)
        else $error("refresh ack");
    a_refresh_preset: assert property (min_search_refresh |=>
        lowest_drain_voltage_result[7:0] == 8'h7F && !scan_complete_flag) else $error("preset");
    a_frame_valid_clear: assert property ($rose(spi_cs_n) ##1 (!slot_one_conv_done)[*6]
        |-> !meas_slot_one_report[7]) else $error("slot valid kept");
    a_min_valid_clear: assert property ($rose(spi_cs_n) ##1 (!scan_step)[*6]
        |-> !lowest_drain_voltage_result[7]) else $error("min valid kept");
    a_fault_clear: assert property (clear_error_control && !slot_one_conv_done
        && !slot_two_conv_done && !scan_step |=> channel_uv_fault == 32'h0) else $error("uv");
    a_done_after_scan: assert property (scan_complete_flag == (step_cnt_reg == 6'h20))
        else $error("scan done");
    a_min_never_rises: assert property (!min_search_refresh |=>
        lowest_drain_voltage_result[6:0] <= $past(lowest_drain_voltage_result[6:0]))
        else $error("min rose");
    a_oe_idle_high: assert property (spi_cs_n[*4] |-> spi_miso_oe_n)
        else $error("miso driven idle");
endmodule
bind arfs_readback arfs_readback_sva u_arfs_readback_sva (.mclk, .rstn, .spi_cs_n,
    .spi_miso_oe_n, .clear_error_control, .min_search_refresh, .slot_one_conv_done,
    .slot_one_conv_value, .slot_two_conv_done, .slot_two_conv_value, .scan_step,
    .channel_uv_fault, .min_search_refresh_ack, .meas_slot_one_report,
    .meas_slot_two_report, .lowest_drain_voltage_result, .scan_complete_flag);

// ==== verif/arfs_host_model.sv ====
// Partner model: host SPI master reading whole read packets
`timescale 1ns/1ns
module arfs_host_model (
    output logic spi_sclk,
    output logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n,
    output logic [437:0] pkt
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        pkt = '0;
    end
    // Clock stands still low between frames
    task automatic read_frame();
        spi_cs_n = 1'b0;
        #200;
        for (int i = 0; i < 438; i++) begin
            spi_sclk = 1'b1;
            // Released line reads as pulled high; reserved bits kept raw, never used
            pkt[i] = spi_miso_oe_n ? 1'b1 : spi_miso;
            #200;
            spi_sclk = 1'b0;
            #200;
        end
        spi_cs_n = 1'b1;
        #400;
    endtask
endmodule

// ==== verif/testbench.sv ====
// Testbench: conversions, faults, minimum search and packet reads
`timescale 1ns/1ns
module testbench;
    logic mclk, rstn, spi_sclk, spi_cs_n, spi_miso, spi_miso_oe_n, write_done;
    logic [5:0] slot_one_channel_select, slot_two_channel_select;
    logic [6:0] under_voltage_threshold, slot_one_conv_value, slot_two_conv_value, scan_value;
    logic clear_error_control, min_search_refresh, slot_one_conv_done, slot_two_conv_done;
    logic slot_one_skip_control, slot_two_skip_control, scan_step, min_search_refresh_ack;
    logic [31:0] ovt_event, channel_uv_fault;
    logic [7:0] meas_slot_one_report, meas_slot_two_report;
    logic [12:0] lowest_drain_voltage_result;
    logic scan_complete_flag;
    logic [437:0] pkt;
    int err_total, check_count, cyc;
    arfs_readback u_arfs_readback (.mclk, .rstn, .spi_sclk, .spi_cs_n, .spi_miso,
        .spi_miso_oe_n, .slot_one_channel_select, .slot_two_channel_select, .write_done,
        .under_voltage_threshold, .clear_error_control, .min_search_refresh,
        .slot_one_conv_done, .slot_one_conv_value, .slot_two_conv_done, .slot_two_conv_value,
        .ovt_event, .slot_one_skip_control, .slot_two_skip_control, .scan_step, .scan_value,
        .channel_uv_fault, .min_search_refresh_ack, .meas_slot_one_report,
        .meas_slot_two_report, .lowest_drain_voltage_result, .scan_complete_flag);
    arfs_host_model u_arfs_host_model (.spi_sclk, .spi_cs_n, .spi_miso, .spi_miso_oe_n, .pkt);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk) s = 1'b1;
        @(negedge mclk) s = 1'b0;
    endtask
    task test_done;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {rstn, write_done, clear_error_control, min_search_refresh, scan_step} = '0;
        {slot_one_conv_done, slot_two_conv_done, slot_one_skip_control} = '0;
        {slot_two_skip_control, slot_one_channel_select, slot_two_channel_select} = '0;
        {slot_one_conv_value, slot_two_conv_value, scan_value, ovt_event} = '0;
        under_voltage_threshold = 7'h20;
        repeat (4) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        chk(lowest_drain_voltage_result, 16'h007F);
        chk({meas_slot_two_report, meas_slot_one_report}, 16'h0000);
        slot_one_channel_select = 6'h05;
        slot_two_channel_select = 6'h20;
        pulse(write_done);
        {slot_one_channel_select, slot_two_channel_select} = '0;
        @(negedge mclk) {slot_one_conv_value, slot_two_conv_value} = {7'h12, 7'h15};
        {slot_one_conv_done, slot_two_conv_done, ovt_event} = {2'b11, 32'h21};
        @(negedge mclk) {slot_one_conv_done, slot_two_conv_done, ovt_event} = '0;
        @(negedge mclk) chk({meas_slot_one_report, meas_slot_two_report}, 16'h9295);
        chk(channel_uv_fault[5], 1'b1);
        u_arfs_host_model.read_frame();
        chk({pkt[397:392], pkt[389:384]}, {6'h05, 6'h20});
        chk(pkt[415:400], 16'h9295);
        chk(pkt[422:416], 7'h3C);
        repeat (8) @(negedge mclk);
        chk({meas_slot_two_report[7], meas_slot_one_report[7]}, 2'b00);
        pulse(clear_error_control);
        slot_one_skip_control = 1'b1;
        u_arfs_host_model.read_frame();
        chk(pkt[422:416], 7'h40);
        chk({pkt[415], pkt[407]}, 2'b00);
        // Slot two moves to ch 9 and reads it under threshold
        {slot_one_channel_select, slot_two_channel_select} = {6'h05, 6'h09};
        pulse(write_done);
        @(negedge mclk) {slot_two_conv_done, slot_two_conv_value} = {1'b1, 7'h08};
        @(negedge mclk) slot_two_conv_done = 1'b0;
        chk(channel_uv_fault[9], 1'b1);
        pulse(min_search_refresh);
        chk({scan_complete_flag, lowest_drain_voltage_result[7:0]}, 9'h07F);
        // Ch 9 carries an under-voltage fault, ch 5 skipped: both below the true minimum
        for (int i = 0; i < 32; i++) begin
            @(negedge mclk) scan_step = 1'b1;
            scan_value = (i == 9) ? 7'h08 : (i == 5) ? 7'h21 : (i == 20) ? 7'h22 : 7'h30 + i;
            @(negedge mclk) scan_step = 1'b0;
        end
        @(negedge mclk) chk(lowest_drain_voltage_result, {5'd20, 1'b1, 7'h22});
        chk({scan_complete_flag, channel_uv_fault[9]}, 2'b11);
        u_arfs_host_model.read_frame();
        chk(pkt[437:424], {1'b1, 5'd20, 1'b1, 7'h22});
        repeat (8) @(negedge mclk);
        chk(lowest_drain_voltage_result[7], 1'b0);
        test_done();
    end
endmodule
